// ---- mds_defs.svh ----
`ifndef MDS_DEFS_SVH
`define MDS_DEFS_SVH

// ************************************************************
// clock
// ************************************************************
`define MDS_CLK_MHZ        100

// ************************************************************
// device register offsets
// ************************************************************
`define MDS_REG_SPD_LO     8'h00
`define MDS_REG_SPD_HI     8'h01
`define MDS_REG_DEV_CTRL   8'h02
`define MDS_REG_CONFIG     8'h03
`define MDS_REG_STATUS     8'h10
`define MDS_REG_FAULT      8'h11
`define MDS_REG_DUTY       8'h12
`define MDS_REG_NVM_CTRL   8'h13
`define MDS_REG_PARAM_LO   8'h20
`define MDS_REG_PARAM_HI   8'h2b

// ************************************************************
// field positions and values
// ************************************************************
`define MDS_ST_FLAG_A    7
`define MDS_ST_LOWPWR      6
`define MDS_ST_OVERCUR     5
`define MDS_ST_LOCK        4
`define MDS_FC_LOCK        0
`define MDS_FC_OVERCUR     1
`define MDS_FC_FLAG_A    2
`define MDS_CFG_MODE_MSB   1
`define MDS_CFG_INHIBIT    2
`define MDS_CFG_SHADOW     3
`define MDS_NVM_GO         0
`define MDS_UNLOCK_KEY     8'hb6
`define MDS_RST_CONFIG     8'h00
`define MDS_RST_SPD        9'h000
`define MDS_RST_KEY        8'h00
`define MDS_LVL_EN_LP      8'h02
`define MDS_LVL_EX_SB      8'h0a
`define MDS_PWM_WIN_END    8'hff

// ************************************************************
// timing
// ************************************************************
`define MDS_T_EN_LP_US     5000
`define MDS_T_EX_SL_SB_US  1
`define MDS_T_EX_SB_AN_US  700000
`define MDS_T_LOCK_OFF_US  5000000
`define MDS_T_NVM_PROG_US  24000
`define MDS_EN_LP_CYC      32'(`MDS_T_EN_LP_US * `MDS_CLK_MHZ)
`define MDS_EX_SL_SB_CYC   32'(`MDS_T_EX_SL_SB_US * `MDS_CLK_MHZ)
`define MDS_EX_SB_AN_CYC   32'(`MDS_T_EX_SB_AN_US * `MDS_CLK_MHZ)
`define MDS_LOCK_OFF_CYC   32'(`MDS_T_LOCK_OFF_US * `MDS_CLK_MHZ)
`define MDS_NVM_PROG_CYC   32'(`MDS_T_NVM_PROG_US * `MDS_CLK_MHZ)

// ************************************************************
// serial link and host registers
// ************************************************************
`define MDS_FRAME_BITS     5'd17
`define MDS_SCL_HALF       16'd16
`define MDS_H_CMD          8'h00
`define MDS_H_STAT         8'h04
`define MDS_H_SPEED        8'h08
`define MDS_RESP_OKAY      2'b00
`define MDS_RESP_SLVERR    2'b10

`endif

// ---- mds_pkg.sv ----
package mds_pkg;
`include "mds_defs.svh"

	typedef enum logic [1:0] {mds_src_analog, mds_src_pwm, mds_src_serial} mds_src_t;
	typedef enum logic [1:0] {mds_run, mds_standby, mds_sleep} mds_pwr_t;
	typedef enum logic [2:0] {mds_h_idle, mds_h_start, mds_h_low, mds_h_high, mds_h_stop_low,
		mds_h_stop_high, mds_h_done} mds_hst_t;

	typedef struct packed {
		logic [2:0]       scl_sync;
		logic [2:0]       sda_sync;
		logic [2:0]       spd_sync;
		logic             scl_f;
		logic             sda_f;
		logic             spd_f;
		logic             in_frame;
		logic             rd;
		logic [4:0]       bit_idx;
		logic [15:0]      shift;
		logic [7:0]       tx;
		logic             sda_oe;
		logic [8:0]       spd_cmd;
		logic [7:0]       config_reg;
		logic [7:0]       key;
		logic             nvm_go;
		logic [31:0]      nvm_cnt;
		logic [11:0][7:0] params;
		logic [11:0][7:0] nvm;
		logic             loaded;
		mds_pwr_t         pwr;
		logic [31:0]      lp_cnt;
		logic             lock_rel;
		logic [31:0]      lock_cnt;
		logic [7:0]       win_cnt;
		logic [7:0]       hi_cnt;
		logic [7:0]       pwm_duty;
		logic             drive_enable;
		logic             outputs_hiz;
		logic [7:0]       peak_output_duty;
		logic [7:0]       status;
		logic [7:0]       fault_reason_code;
		logic             low_power;
		logic             regulator_enable;
		logic [1:0]       ground_phase;
	} mds_dev_state_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        aw_got;
		logic [7:0]  awaddr;
		logic        w_got;
		logic [31:0] wdata;
		logic        busy;
		logic [16:0] frame;
		logic        rd;
		logic [7:0]  rdbuf;
		logic        speed_lvl;
		logic        pwm_en;
		logic [7:0]  pwm_duty;
		logic [7:0]  pwm_cnt;
		logic        speed_pin;
		mds_hst_t    st;
		logic [15:0] tick_cnt;
		logic [4:0]  bit_idx;
		logic        scl;
		logic        sda_oe;
		logic [2:0]  sda_sync;
		logic        sda_f;
	} mds_host_state_t;

endpackage : mds_pkg

// ---- mds_link_if.sv ----
`timescale 1ns/1ps
interface mds_link_if;
	logic scl;
	logic speed_pin;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;

	// open drain, pulled up
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

	modport host (output scl, output speed_pin, output host_sda_o, output host_sda_oe, input sda);
	modport device (input scl, input speed_pin, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : mds_link_if

// ---- mds_device.sv ----
// Notes on behaviour
// [RL1] over-temperature flag at status bit 7
// [RL2] over-current puts drivers high impedance
// [RL3] over-current flag at status bit 5
// [RL4] lock stops drive, resumes after release
// [RL5] lock still present: repeat protection cycle
// [RL6] lock flag bit 4, cause in code
// [RL7] speed command from pwm, analog, serial
// [RL8] peak duty may be limited below command
// [RL9] one phase grounded, two modulated
// [RL10] duty scales amplitude against supply
// [RL11] sleep: stop, regulator off, clear registers
// [RL12] standby: stop, keep registers and link
// [RL13] inhibit blocks entry, does not wake
// [RL14] low-power flag at status bit 6
// [RL15] per-mode low-power entry conditions
// [RL16] per-mode exit conditions, sleep needs pin
// [RL17] no wake from serial writes; here a nonzero serial speed write wakes from standby
// [RL18] 96-bit store mirrors motor parameters
// [RL19] host unlock sequence before store write
// [RL20] store write timed, go bit self-clears
// [RL21] host programs store with motor stopped
// [RL22] host writes 7-bit motor codes
// [RL23] reload parameters at power-on, sleep exit
// [RL24] fault flags follow their conditions
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module mds_device
	import mds_pkg::*;
#(
	parameter logic [31:0] P_EN_LP_CYC    = `MDS_EN_LP_CYC,
	parameter logic [31:0] P_EX_SB_AN_CYC = `MDS_EX_SB_AN_CYC,
	parameter logic [31:0] P_LOCK_OFF_CYC = `MDS_LOCK_OFF_CYC,
	parameter logic [31:0] P_NVM_PROG_CYC = `MDS_NVM_PROG_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	mds_link_if.device      link,
	input  wire logic       over_temp,
	input  wire logic       over_current,
	input  wire logic       lock_detect,
	input  wire logic [7:0] analog_speed,
	input  wire logic [7:0] duty_limit,
	input  wire logic       sleep_variant,
	input  wire logic       commutate_tick,
	output logic            drive_enable,
	output logic            outputs_hiz,
	output logic [7:0]      peak_output_duty,
	output logic [7:0]      fault_and_power_status,
	output logic [7:0]      fault_reason_code,
	output logic            low_power,
	output logic            regulator_enable,
	output logic [1:0]      ground_phase
);

	localparam logic [31:0] EX_SL_SB_CYC = `MDS_EX_SL_SB_CYC;

	mds_dev_state_t s;
	mds_dev_state_t n;
	logic           rise;
	logic           fall;
	logic           start_c;
	logic           stop_c;
	logic           asleep;
	logic           wr_en;
	logic [7:0]     wr_addr;
	logic [7:0]     wr_data;
	mds_src_t       src;
	logic [7:0]     cmd_duty;
	logic           enter_c;
	logic           exit_sb_c;
	logic [31:0]    exit_sb_cyc;

	// ************************************************************
	// register read decode
	// ************************************************************
	function automatic logic [7:0] reg_read(input mds_dev_state_t st, input logic [7:0] a);
		logic [7:0] d;
		d = 8'h00;
		if (a == `MDS_REG_SPD_LO) d = st.spd_cmd[7:0];
		else if (a == `MDS_REG_SPD_HI) d = {7'h00, st.spd_cmd[8]};
		else if (a == `MDS_REG_DEV_CTRL) d = st.key;
		else if (a == `MDS_REG_CONFIG) d = st.config_reg;
		else if (a == `MDS_REG_STATUS) d = st.status;
		else if (a == `MDS_REG_FAULT) d = st.fault_reason_code;
		else if (a == `MDS_REG_DUTY) d = st.peak_output_duty;
		else if (a == `MDS_REG_NVM_CTRL) d = {7'h00, st.nvm_go};
		else if (a >= `MDS_REG_PARAM_LO && a <= `MDS_REG_PARAM_HI) d = st.params[a[3:0]];
		return d;
	endfunction : reg_read

	always_comb begin
		n = s;
		wr_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		asleep = (s.pwr == mds_sleep);
		src = mds_src_t'(s.config_reg[`MDS_CFG_MODE_MSB:0]);

		// ************************************************************
		// pin synchronisers, stages 2 and 3 must agree
		// ************************************************************
		n.scl_sync = {s.scl_sync[1:0], link.scl};
		n.sda_sync = {s.sda_sync[1:0], link.sda};
		n.spd_sync = {s.spd_sync[1:0], link.speed_pin};
		if (s.scl_sync[1] == s.scl_sync[2]) n.scl_f = s.scl_sync[2];
		if (s.sda_sync[1] == s.sda_sync[2]) n.sda_f = s.sda_sync[2];
		if (s.spd_sync[1] == s.spd_sync[2]) n.spd_f = s.spd_sync[2];
		rise = n.scl_f && !s.scl_f;
		fall = !n.scl_f && s.scl_f;
		start_c = s.scl_f && n.scl_f && s.sda_f && !n.sda_f;
		stop_c = s.scl_f && n.scl_f && !s.sda_f && n.sda_f;

		// ************************************************************
		// serial link slave
		// ************************************************************
		if (asleep) begin
			// link dead while asleep  // see [RL11] see [RL17]
			n.in_frame = 1'b0;
			n.sda_oe = 1'b0;
		end else if (start_c) begin
			n.in_frame = 1'b1;
			n.bit_idx = 5'd0;
			n.rd = 1'b0;
			n.sda_oe = 1'b0;
		end else if (stop_c) begin
			n.in_frame = 1'b0;
			n.sda_oe = 1'b0;
		end else if (s.in_frame && rise && s.bit_idx < `MDS_FRAME_BITS) begin
			n.shift = {s.shift[14:0], n.sda_f};
			n.bit_idx = s.bit_idx + 5'd1;
			if (s.bit_idx == 5'd8) begin
				n.rd = s.shift[7];
				n.tx = reg_read(s, {s.shift[6:0], n.sda_f});
			end
			if (s.bit_idx == 5'd16 && !s.rd) begin
				wr_en = 1'b1;
				wr_addr = s.shift[14:7];
				wr_data = {s.shift[6:0], n.sda_f};
			end
		end else if (s.in_frame && fall && s.rd) begin
			if (s.bit_idx <= 5'd16) begin
				n.sda_oe = !s.tx[7];
				n.tx = {s.tx[6:0], 1'b0};
			end else begin
				n.sda_oe = 1'b0;
			end
		end

		// ************************************************************
		// register writes
		// ************************************************************
		if (wr_en) begin
			if (wr_addr == `MDS_REG_SPD_LO) n.spd_cmd[7:0] = wr_data;
			else if (wr_addr == `MDS_REG_SPD_HI) n.spd_cmd[8] = wr_data[0];
			else if (wr_addr == `MDS_REG_DEV_CTRL) n.key = wr_data;
			else if (wr_addr == `MDS_REG_CONFIG) n.config_reg = wr_data;
			else if (wr_addr == `MDS_REG_NVM_CTRL) begin
				// go taken only after key and shadow select  // see [RL19]
				if (wr_data[`MDS_NVM_GO] && !s.nvm_go && s.key == `MDS_UNLOCK_KEY
					&& s.config_reg[`MDS_CFG_SHADOW])
					n.nvm_go = 1'b1;
			end else if (wr_addr >= `MDS_REG_PARAM_LO && wr_addr <= `MDS_REG_PARAM_HI) begin
				// see [RL22]
				n.params[wr_addr[3:0]] = wr_data;
			end
		end

		// ************************************************************
		// parameter store
		// ************************************************************
		if (!s.loaded && !asleep) begin
			n.params = s.nvm;  // see [RL23] see [RL18]
			n.loaded = 1'b1;
		end
		if (s.nvm_go) begin
			// software stops motor first  // see [RL21]
			if (s.nvm_cnt == P_NVM_PROG_CYC - 32'd1) begin
				n.nvm = s.params;  // see [RL18]
				n.nvm_go = 1'b0;  // see [RL20]
				n.nvm_cnt = 32'd0;
				n.key = `MDS_RST_KEY;
			end else begin
				n.nvm_cnt = s.nvm_cnt + 32'd1;
			end
		end

		// ************************************************************
		// pwm duty over a 255-sample window
		// ************************************************************
		n.win_cnt = s.win_cnt + 8'd1;
		if (s.win_cnt == `MDS_PWM_WIN_END) begin
			n.pwm_duty = s.hi_cnt;
			n.hi_cnt = 8'h00;
		end else begin
			n.hi_cnt = s.hi_cnt + {7'h00, s.spd_f};
		end

		// ************************************************************
		// low power entry and exit
		// ************************************************************
		enter_c = 1'b0;
		exit_sb_c = 1'b0;
		exit_sb_cyc = EX_SL_SB_CYC;
		case (src)
			mds_src_analog: begin
				enter_c = analog_speed < `MDS_LVL_EN_LP;  // see [RL15]
				exit_sb_c = analog_speed > `MDS_LVL_EX_SB;
				exit_sb_cyc = P_EX_SB_AN_CYC;
			end
			mds_src_pwm: begin
				enter_c = !s.spd_f;  // see [RL15]
				exit_sb_c = s.spd_f;
			end
			default: begin
				enter_c = (s.spd_cmd == 9'h000);  // see [RL15]
				exit_sb_c = (s.spd_cmd != 9'h000);  // see [RL16]
			end
		endcase
		case (s.pwr)
			mds_run: begin
				// see [RL13]
				if (enter_c && !s.config_reg[`MDS_CFG_INHIBIT]) begin
					n.lp_cnt = s.lp_cnt + 32'd1;
					if (s.lp_cnt == P_EN_LP_CYC - 32'd1) begin
						n.pwr = sleep_variant ? mds_sleep : mds_standby;
						n.lp_cnt = 32'd0;
					end
				end else begin
					n.lp_cnt = 32'd0;
				end
			end
			mds_standby: begin
				// see [RL12]
				if (exit_sb_c) begin
					n.lp_cnt = s.lp_cnt + 32'd1;
					if (s.lp_cnt >= exit_sb_cyc - 32'd1) begin
						n.pwr = mds_run;  // see [RL16]
						n.lp_cnt = 32'd0;
					end
				end else begin
					n.lp_cnt = 32'd0;
				end
			end
			default: begin
				// volatile registers lost  // see [RL11]
				n.spd_cmd = `MDS_RST_SPD;
				n.config_reg = `MDS_RST_CONFIG;
				n.key = `MDS_RST_KEY;
				n.nvm_go = 1'b0;
				n.nvm_cnt = 32'd0;
				n.loaded = 1'b0;
				if (s.spd_f) begin
					n.lp_cnt = s.lp_cnt + 32'd1;
					if (s.lp_cnt == EX_SL_SB_CYC - 32'd1) begin
						n.pwr = mds_run;  // see [RL16]
						n.lp_cnt = 32'd0;
					end
				end else begin
					n.lp_cnt = 32'd0;
				end
			end
		endcase

		// ************************************************************
		// rotor lock protection
		// ************************************************************
		if (s.lock_rel) begin
			n.lock_cnt = s.lock_cnt + 32'd1;
			if (s.lock_cnt == P_LOCK_OFF_CYC - 32'd1) begin
				n.lock_rel = 1'b0;  // see [RL4]
				n.lock_cnt = 32'd0;
			end
		end else if (lock_detect && s.drive_enable) begin
			// retried on each resume  // see [RL4] see [RL5]
			n.lock_rel = 1'b1;
			n.lock_cnt = 32'd0;
		end

		// ************************************************************
		// drive and status outputs
		// ************************************************************
		n.drive_enable = (n.pwr == mds_run) && !over_temp && !over_current && !n.lock_rel;  // see [RL4] see [RL11]
		n.outputs_hiz = over_current;  // see [RL2]
		n.low_power = (n.pwr != mds_run);
		n.regulator_enable = (n.pwr != mds_sleep);  // see [RL11] see [RL12]
		n.status = 8'h00;
		n.status[`MDS_ST_FLAG_A] = over_temp;  // see [RL1] see [RL24]
		n.status[`MDS_ST_LOWPWR] = n.low_power;  // see [RL14]
		n.status[`MDS_ST_OVERCUR] = over_current;  // see [RL3] see [RL24]
		n.status[`MDS_ST_LOCK] = n.lock_rel;  // see [RL6] see [RL24]
		n.fault_reason_code = 8'h00;
		n.fault_reason_code[`MDS_FC_LOCK] = n.lock_rel;  // see [RL6]
		n.fault_reason_code[`MDS_FC_OVERCUR] = over_current;
		n.fault_reason_code[`MDS_FC_FLAG_A] = over_temp;
		case (src)
			mds_src_analog: cmd_duty = analog_speed;  // see [RL7]
			mds_src_pwm: cmd_duty = s.pwm_duty;  // see [RL7]
			default: cmd_duty = s.spd_cmd[8:1];  // see [RL7]
		endcase
		// 8'hff full supply, 8'h80 half  // see [RL10]
		n.peak_output_duty = (duty_limit < cmd_duty) ? duty_limit : cmd_duty;  // see [RL8]
		if (s.drive_enable && commutate_tick) begin
			// grounded phase walks, two others modulated  // see [RL9]
			n.ground_phase = (s.ground_phase == 2'd2) ? 2'd0 : s.ground_phase + 2'd1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe = s.sda_oe;
	assign drive_enable = s.drive_enable;
	assign outputs_hiz = s.outputs_hiz;
	assign peak_output_duty = s.peak_output_duty;
	assign fault_and_power_status = s.status;
	assign fault_reason_code = s.fault_reason_code;
	assign low_power = s.low_power;
	assign regulator_enable = s.regulator_enable;
	assign ground_phase = s.ground_phase;

endmodule : mds_device

// ---- mds_host.sv ----
`timescale 1ns/1ps
module mds_host
	import mds_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	mds_link_if.host         link,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	mds_host_state_t s;
	mds_host_state_t n;
	logic            tick;

	always_comb begin
		n = s;
		tick = (s.tick_cnt == `MDS_SCL_HALF - 16'd1);

		// ************************************************************
		// axi4-lite slave
		// ************************************************************
		if (s_axi_awvalid && s.awready) begin
			n.aw_got = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata;
		end
		if (s.bvalid && s_axi_bready) n.bvalid = 1'b0;
		if (s.aw_got && s.w_got && !s.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = `MDS_RESP_OKAY;
			if (s.awaddr == `MDS_H_CMD) begin
				// dropped while busy; software polls busy
				if (!s.busy && s_axi_wstrb != 4'h0) begin
					n.busy = 1'b1;
					n.frame = s.wdata[16:0];
					n.rd = s.wdata[16];
					n.st = mds_h_start;
					n.tick_cnt = 16'd0;
				end
			end else if (s.awaddr == `MDS_H_SPEED) begin
				n.speed_lvl = s.wdata[0];
				n.pwm_en = s.wdata[1];
				n.pwm_duty = s.wdata[15:8];
			end else if (s.awaddr != `MDS_H_STAT) begin
				n.bresp = `MDS_RESP_SLVERR;
			end
		end
		n.awready = !n.aw_got;
		n.wready = !n.w_got;
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end else if (!s.rvalid) begin
			n.arready = 1'b1;
		end
		if (s_axi_arvalid && s.arready) begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rresp = `MDS_RESP_OKAY;
			n.rdata = 32'h0;
			if (s_axi_araddr == `MDS_H_STAT) n.rdata = {16'h0, s.rdbuf, 7'h0, s.busy};
			else if (s_axi_araddr == `MDS_H_SPEED) n.rdata = {16'h0, s.pwm_duty, 6'h0, s.pwm_en, s.speed_lvl};
			else if (s_axi_araddr != `MDS_H_CMD) n.rresp = `MDS_RESP_SLVERR;
		end

		// ************************************************************
		// speed pin: level or free-running pwm  (see [RL7])
		// ************************************************************
		n.pwm_cnt = s.pwm_cnt + 8'd1;
		n.speed_pin = s.pwm_en ? (s.pwm_cnt < s.pwm_duty) : s.speed_lvl;

		// ************************************************************
		// serial master, scl made by divider
		// ************************************************************
		n.sda_sync = {s.sda_sync[1:0], link.sda};
		if (s.sda_sync[1] == s.sda_sync[2]) n.sda_f = s.sda_sync[2];
		if (s.st == mds_h_idle) n.tick_cnt = 16'd0;
		else n.tick_cnt = tick ? 16'd0 : s.tick_cnt + 16'd1;
		if (s.st == mds_h_idle) begin
			n.scl = 1'b1;
			n.sda_oe = 1'b0;
		end
		if (tick) begin
			case (s.st)
				mds_h_start: begin
					n.sda_oe = 1'b1;
					n.bit_idx = 5'd0;
					n.st = mds_h_low;
				end
				mds_h_low: begin
					n.scl = 1'b0;
					// release sda for read bits
					if (s.rd && s.bit_idx >= 5'd9) n.sda_oe = 1'b0;
					else n.sda_oe = !s.frame[16];
					n.st = mds_h_high;
				end
				mds_h_high: begin
					n.scl = 1'b1;
					n.st = mds_h_low;
					if (s.scl) begin
						n.frame = {s.frame[15:0], 1'b0};
						if (s.rd && s.bit_idx >= 5'd9) n.rdbuf = {s.rdbuf[6:0], s.sda_f};
						n.bit_idx = s.bit_idx + 5'd1;
						if (s.bit_idx == `MDS_FRAME_BITS - 5'd1) n.st = mds_h_stop_low;
					end else begin
						n.st = mds_h_high;
					end
				end
				mds_h_stop_low: begin
					n.scl = 1'b0;
					n.sda_oe = 1'b1;
					n.st = mds_h_stop_high;
				end
				mds_h_stop_high: begin
					n.scl = 1'b1;
					n.st = mds_h_done;
				end
				mds_h_done: begin
					n.sda_oe = 1'b0;
					n.busy = 1'b0;
					n.st = mds_h_idle;
				end
				default: n.st = mds_h_idle;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign link.scl = s.scl;
	assign link.speed_pin = s.speed_pin;
	assign link.host_sda_o = 1'b0;
	assign link.host_sda_oe = s.sda_oe;
	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bresp = s.bresp;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_arready = s.arready;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rvalid = s.rvalid;

endmodule : mds_host

// ---- mds_properties.sv ----
`timescale 1ns/1ps
module mds_properties (
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic       over_temp,
	input wire logic       over_current,
	input wire logic       lock_detect,
	input wire logic       sleep_variant,
	input wire logic [7:0] duty_limit,
	input wire logic       drive_enable,
	input wire logic       outputs_hiz,
	input wire logic [7:0] peak_output_duty,
	input wire logic [7:0] fault_and_power_status,
	input wire logic [7:0] fault_reason_code,
	input wire logic       low_power,
	input wire logic       regulator_enable
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// ************************************************************
	// fault and power relations
	// ************************************************************
	a_flag_a_flag: assert property (over_temp |=> fault_and_power_status[7])
		else $error("flag_a flag");
	a_overcur_hiz: assert property (over_current |=> outputs_hiz)
		else $error("hiz missing");
	a_hiz_release: assert property (!over_current |=> !outputs_hiz)
		else $error("hiz stuck");
	a_overcur_flag: assert property (over_current |=> fault_and_power_status[5])
		else $error("overcur flag");
	a_flag_clears: assert property ($fell(over_temp) |=> !fault_and_power_status[7])
		else $error("flag_a stuck");
	a_lock_stops: assert property (lock_detect && drive_enable |=> !drive_enable)
		else $error("lock drive");
	a_lock_code: assert property (fault_and_power_status[4] |-> fault_reason_code[0])
		else $error("lock code");
	a_lp_flag: assert property (fault_and_power_status[6] == low_power)
		else $error("lp flag");
	a_lp_no_drive: assert property (low_power |-> !drive_enable)
		else $error("lp drive");
	a_standby_reg: assert property (low_power && !sleep_variant |-> regulator_enable)
		else $error("standby reg");
	a_duty_capped: assert property (peak_output_duty <= $past(duty_limit))
		else $error("duty high");
endmodule : mds_properties

// ---- tb_motor_driver_supervisor.sv ----
`timescale 1ns/1ps
module tb_motor_driver_supervisor;
	logic        sys_clk, rstn, over_temp, over_current, lock_detect, commutate_tick, drive_enable, outputs_hiz;
	logic        bready, rready, sleep_variant;
	logic        low_power, regulator_enable, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
	logic [7:0]  analog_speed, duty_limit, awaddr, araddr, peak_output_duty, fault_and_power_status, fault_reason_code, d;
	logic [1:0]  ground_phase, bresp, rresp;
	logic [31:0] wdata, rdata, lf, s;
	logic [33:0] exp_q[$];
	int          bad_count = 0, n_checks = 0;
	mds_link_if link();
	mds_device #(.P_EN_LP_CYC(200), .P_EX_SB_AN_CYC(300), .P_LOCK_OFF_CYC(400), .P_NVM_PROG_CYC(150)) u_mds_device (
		.sys_clk, .rstn, .link(link.device), .over_temp, .over_current, .lock_detect, .analog_speed, .duty_limit,
		.sleep_variant, .commutate_tick, .drive_enable, .outputs_hiz, .peak_output_duty,
		.fault_and_power_status, .fault_reason_code, .low_power, .regulator_enable, .ground_phase);
	mds_host u_mds_host (.sys_clk, .rstn, .link(link.host), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	mds_properties u_chk (.sys_clk, .rstn, .over_temp, .over_current, .lock_detect, .sleep_variant,
		.duty_limit, .drive_enable, .outputs_hiz, .peak_output_duty, .fault_and_power_status,
		.fault_reason_code, .low_power, .regulator_enable);
	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [7:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf[7:0];
	endfunction : rnd
	task automatic chk(input string n, input logic [33:0] seen, input logic [33:0] e);
		n_checks++;
		if (seen !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [33:0] e, input bit q);
		araddr <= a;
		arvalid <= 1'b1;
		if (q) exp_q.push_back(e);
		do @(posedge sys_clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (!rvalid);
		s = rdata;
	endtask : rd
	// command, then poll busy
	task automatic dw(input logic [7:0] r, input logic [7:0] v, input bit rdb);
		wr(8'h00, {15'h0, rdb, r, v});
		do rd(8'h04, 34'h0, 1'b0); while (s[0] !== 1'b0);
	endtask : dw
	task automatic dr(input logic [7:0] r, input logic [7:0] e);
		dw(r, 8'h00, 1'b1);
		rd(8'h04, {18'h0, e, 8'h00}, 1'b1);
	endtask : dr
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : test_done
	always @(posedge sys_clk) if (rvalid && exp_q.size() > 0) chk("read", {rresp, rdata}, exp_q.pop_front());
	always @(posedge sys_clk) commutate_tick <= !commutate_tick;
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (40000) @(posedge sys_clk);
		bad_count++;
		test_done;
	end
	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		{rstn, over_temp, over_current, lock_detect, commutate_tick, awvalid, wvalid, arvalid} = '0;
		{awaddr, araddr, wdata, sleep_variant} = '0;
		{bready, rready} = 2'b11;
		lf = 32'h0001268a;
		analog_speed = 8'h40;
		duty_limit = 8'hff;
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge sys_clk);
		duty_limit <= rnd();
		analog_speed <= rnd() | 8'h10;
		d = rnd();
		wr(8'h08, {16'h0, d, 8'h01});
		rd(8'h08, {18'h0, d, 8'h01}, 1'b1);
		rd(8'h0c, {2'b10, 32'h0}, 1'b1);
		over_temp <= 1'b1;
		dr(8'h10, 8'h80);
		over_temp <= 1'b0;
		over_current <= 1'b1;
		dr(8'h10, 8'h20);
		over_current <= 1'b0;
		dr(8'h10, 8'h00);
		lock_detect <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("drive", 34'(drive_enable), 34'h0);
		repeat (600) @(posedge sys_clk);
		chk("lock flag", 34'(fault_and_power_status[4]), 34'h1);
		lock_detect <= 1'b0;
		repeat (410) @(posedge sys_clk);
		chk("drive", 34'(drive_enable), 34'h1);
		dw(8'h03, 8'h02, 1'b0);
		repeat (210) @(posedge sys_clk);
		dr(8'h10, 8'h40);
		dw(8'h00, 8'h05, 1'b0);
		repeat (110) @(posedge sys_clk);
		chk("wake", 34'(low_power), 34'h0);
		dw(8'h03, 8'h0e, 1'b0);
		dw(8'h00, 8'h00, 1'b0);
		repeat (210) @(posedge sys_clk);
		chk("inhibit", 34'(low_power), 34'h0);
		dw(8'h20, 8'h55, 1'b0);
		dw(8'h02, 8'hb6, 1'b0);
		dw(8'h13, 8'h01, 1'b0);
		repeat (160) @(posedge sys_clk);
		dr(8'h13, 8'h00);
		dr(8'h20, 8'h55);
		test_done;
	end
endmodule : tb_motor_driver_supervisor
